// file: epa_pkg.sv
package epa_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W = 16;
  localparam int unsigned DEV_W = 20;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STEP_FACTOR = 7'h30;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 7'h31;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE = 7'h32;
  localparam logic [ADDR_W-1:0] OFS_DEV_LIMIT = 7'h33;

  // Reset values
  localparam logic [31:0] RST_STEP_FACTOR = 32'h0001_0000;
  localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;
  localparam logic [DEV_W-1:0] RST_DEV_LIMIT = 20'h0_0000;

  // Flag bit positions
  localparam int unsigned FLG_INDEX = 0;
  localparam int unsigned FLG_DEV = 1;

  // Encoder configuration field positions
  localparam int unsigned CFG_POL_A = 0;
  localparam int unsigned CFG_POL_B = 1;
  localparam int unsigned CFG_POL_N = 2;
  localparam int unsigned CFG_IGNORE_PHASE_POLARITY = 3;
  localparam int unsigned CFG_SENS_LO = 6;
  localparam int unsigned CFG_SENS_HI = 7;
  localparam int unsigned CFG_CLR_ON_IDX = 8;
  localparam int unsigned CFG_DECIMAL = 10;
  localparam int unsigned CFG_SRC_SEL = 11;

  // Index sensitivity encodings
  localparam logic [1:0] SENS_LEVEL = 2'h0;
  localparam logic [1:0] SENS_ACTIVE = 2'h1;
  localparam logic [1:0] SENS_INACTIVE = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;

  // Fixed-point layout of the accumulator
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned ACC_W = 48;
  localparam logic [15:0] DEC_BASE = 16'h2710;
  localparam logic [15:0] DEC_MAX = 16'h270F;

endpackage : epa_pkg

// file: epa_evt_if.sv
`timescale 1ns/1ps
interface epa_evt_if;
  logic step;
  logic dir;
  logic index;

  // Count source, index source and consumer
  modport count (output step, output dir);
  modport idx (output index);
  modport core (input step, input dir, input index);
endinterface : epa_evt_if

// file: epa_quad_dec.sv
`timescale 1ns/1ps
module epa_quad_dec
  import epa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Encoder phases and full-step source
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic bemf_step,
  input wire logic bemf_dir,
  input wire logic source_sel,
  // Decoded counts
  epa_evt_if.count evt
);

  typedef struct packed {
    logic primed;
    logic a;
    logic b;
    logic step;
    logic dir;
  } epa_quad_t;

  epa_quad_t s_q;
  epa_quad_t s_d;
  logic one_change;

  // One phase change per sample is a count; two at once is noise
  always_comb begin
    s_d = s_q;
    one_change = (enc_a ^ s_q.a) ^ (enc_b ^ s_q.b);
    s_d.a = enc_a;
    s_d.b = enc_b;
    s_d.primed = 1'b1;
    if (source_sel) begin
      s_d.step = s_q.primed & one_change;
      s_d.dir = s_q.a ^ enc_b;
    end else begin
      s_d.step = bemf_step;
      s_d.dir = bemf_dir;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.step = s_q.step;
  assign evt.dir = s_q.dir;

  a_quad_phase_step: assert property (
    @(posedge clk) disable iff (!nrst)
    source_sel && s_q.primed && (enc_a != s_q.a) && (enc_b == s_q.b)
    |=> s_q.step)
    else $error("single phase change gave no count");

endmodule : epa_quad_dec

// file: epa_index_det.sv
`timescale 1ns/1ps
module epa_index_det
  import epa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  // Index configuration
  input wire logic pol_a,
  input wire logic pol_b,
  input wire logic pol_n,
  input wire logic ignore_phase_polarity,
  input wire logic [1:0] sens,
  // Index events
  epa_evt_if.idx evt
);

  typedef struct packed {
    logic match;
    logic event_hit;
  } epa_idx_t;

  epa_idx_t s_q;
  epa_idx_t s_d;
  logic match;

  // Edges are taken on the qualified match, so A/B gating applies too
  always_comb begin
    s_d = s_q;
    match = (enc_n == pol_n) &&
            (ignore_phase_polarity || ((enc_a == pol_a) && (enc_b == pol_b)));
    s_d.match = match;
    case (sens)
      SENS_LEVEL: s_d.event_hit = match;
      SENS_ACTIVE: s_d.event_hit = match & ~s_q.match;
      SENS_INACTIVE: s_d.event_hit = ~match & s_q.match;
      SENS_BOTH: s_d.event_hit = match ^ s_q.match;
      default: s_d.event_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.index = s_q.event_hit;

  a_idx_level_mode: assert property (
    @(posedge clk) disable iff (!nrst)
    (sens == SENS_LEVEL) |=> (s_q.event_hit == $past(match)))
    else $error("level mode index does not follow the match");

  a_idx_gate_pol: assert property (
    @(posedge clk) disable iff (!nrst)
    (enc_n != pol_n) |=> !s_q.match)
    else $error("index matched with wrong index polarity");

endmodule : epa_index_det

// file: epa_position_acc.sv
// Behaviour
// - The step factor is a signed 32-bit word, 16 integer and 16 fraction bits.
// - After reset the step factor reads 0x00010000, one count per encoder step.
// - A configuration bit picks binary or decimal scaling of the fraction.
// - Each count adds or subtracts the factor; software picks its sign.
// - An index event sets sticky flag bit 0, cleared by writing one.
// - An index event copies the position into a read-only capture register.
// - Flag bit 1 is set when position and ramp position differ beyond a limit.
// - With the full-step source the deviation is measured against zero.
// - The deviation flag only clears by write-one once the condition is gone.
// - A deviation limit of zero, the reset value, turns the check off.
// - Binary fractions count in 1/65536, decimal fractions in 1/10000.
// - With clear-on-index set the position is zeroed at the capturing event.
// - A two-bit field sets level, active, inactive or both-edge indexing.
// - An index needs N, A and B at their polarities unless A/B is ignored.
`timescale 1ns/1ps
module epa_position_acc
  import epa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Encoder configuration word
  input wire logic [CFG_W-1:0] encoder_config,
  // Encoder pins and full-step source
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_n,
  input wire logic bemf_step,
  input wire logic bemf_dir,
  // Ramp generator
  input wire logic [31:0] ramp_actual_position,
  // Status
  output logic [31:0] enc_position,
  output logic n_event,
  output logic deviation_warn
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [31:0] factor;
    logic [31:0] capture;
    logic [DEV_W-1:0] limit;
    logic idx_flag;
    logic dev_flag;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } epa_core_t;

  epa_core_t s_q;
  epa_core_t s_d;
  epa_evt_if evt ();

  logic decimal;
  logic src_incr;
  logic clr_on_idx;
  logic dev_cond;
  logic flags_clr_idx;
  logic flags_clr_dev;
  logic [31:0] dev_ref;

  // Binary step: plain two's complement add of the sign-extended factor
  function automatic logic [ACC_W-1:0] bin_step(
    input logic [ACC_W-1:0] acc,
    input logic [31:0] f,
    input logic down
  );
    logic [ACC_W-1:0] ext;
    ext = {{(ACC_W-32){f[31]}}, f};
    bin_step = down ? (acc - ext) : (acc + ext);
  endfunction : bin_step

  // Decimal step: sign and magnitude, fraction wraps at 10000 ten-thousandths, one whole count
  function automatic logic [ACC_W-1:0] dec_step(
    input logic [ACC_W-1:0] acc,
    input logic [31:0] f,
    input logic down
  );
    logic sub;
    logic [31:0] mag;
    logic [15:0] fr;
    logic [31:0] ip;
    logic [31:0] ni;
    logic [15:0] nf;
    logic [16:0] t;
    sub = f[31] ^ down;
    mag = f[31] ? (~f + 32'h0000_0001) : f;
    fr = (mag[15:0] > DEC_MAX) ? DEC_MAX : mag[15:0];
    ip = {16'h0000, mag[31:16]};
    if (!sub) begin
      t = {1'b0, acc[FRAC_W-1:0]} + {1'b0, fr};
      if (t >= {1'b0, DEC_BASE}) begin
        nf = t[15:0] - DEC_BASE;
        ni = acc[ACC_W-1:FRAC_W] + ip + 32'h0000_0001;
      end else begin
        nf = t[15:0];
        ni = acc[ACC_W-1:FRAC_W] + ip;
      end
    end else begin
      t = {1'b0, acc[FRAC_W-1:0]} - {1'b0, fr};
      if (t[16]) begin
        nf = t[15:0] + DEC_BASE;
        ni = acc[ACC_W-1:FRAC_W] - ip - 32'h0000_0001;
      end else begin
        nf = t[15:0];
        ni = acc[ACC_W-1:FRAC_W] - ip;
      end
    end
    dec_step = {ni, nf};
  endfunction : dec_step

  // Magnitude of a signed difference, kept unsigned so -2^31 still fits
  function automatic logic [31:0] abs_diff(
    input logic [31:0] a,
    input logic [31:0] b
  );
    logic [31:0] d;
    d = a - b;
    abs_diff = d[31] ? (~d + 32'h0000_0001) : d;
  endfunction : abs_diff

  // Configuration decode
  assign decimal = encoder_config[CFG_DECIMAL];
  assign src_incr = encoder_config[CFG_SRC_SEL];
  assign clr_on_idx = encoder_config[CFG_CLR_ON_IDX];

  epa_quad_dec u_quad (
    .clk(clk),
    .nrst(nrst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .bemf_step(bemf_step),
    .bemf_dir(bemf_dir),
    .source_sel(src_incr),
    .evt(evt.count)
  );

  epa_index_det u_index (
    .clk(clk),
    .nrst(nrst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_n(enc_n),
    .pol_a(encoder_config[CFG_POL_A]),
    .pol_b(encoder_config[CFG_POL_B]),
    .pol_n(encoder_config[CFG_POL_N]),
    .ignore_phase_polarity(encoder_config[CFG_IGNORE_PHASE_POLARITY]),
    .sens(encoder_config[CFG_SENS_HI:CFG_SENS_LO]),
    .evt(evt.idx)
  );

  // Deviation against ramp position, or zero for the full-step source
  assign dev_ref = src_incr ? ramp_actual_position : 32'h0000_0000;
  assign dev_cond = (s_q.limit != RST_DEV_LIMIT) &&
    (abs_diff(s_q.acc[ACC_W-1:FRAC_W], dev_ref) >
     {{(32-DEV_W){1'b0}}, s_q.limit});

  // Write-one clears on the flags register
  assign flags_clr_idx = reg_wr && (reg_addr == OFS_FLAGS) &&
    reg_wdata[FLG_INDEX];
  assign flags_clr_dev = reg_wr && (reg_addr == OFS_FLAGS) &&
    reg_wdata[FLG_DEV];

  // Next state; an index clear takes priority over a count in the same cycle
  always_comb begin
    s_d = s_q;
    s_d.rvalid = reg_rd;
    if (evt.step) begin
      if (decimal) begin
        s_d.acc = dec_step(s_q.acc, s_q.factor, ~evt.dir);
      end else begin
        s_d.acc = bin_step(s_q.acc, s_q.factor, ~evt.dir);
      end
    end
    if (evt.index) begin
      s_d.capture = s_q.acc[ACC_W-1:FRAC_W];
      if (clr_on_idx) begin
        s_d.acc = '0;
      end
    end
    // Set wins over clear so an event in the clearing cycle survives
    s_d.idx_flag = evt.index | (s_q.idx_flag & ~flags_clr_idx);
    s_d.dev_flag = dev_cond | (s_q.dev_flag & ~flags_clr_dev);
    if (reg_wr) begin
      case (reg_addr)
        OFS_STEP_FACTOR: s_d.factor = reg_wdata;
        OFS_DEV_LIMIT: s_d.limit = reg_wdata[DEV_W-1:0];
        default: s_d.factor = s_d.factor;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_STEP_FACTOR: s_d.rdata = s_q.factor;
        OFS_FLAGS: s_d.rdata = {30'h0, s_q.dev_flag, s_q.idx_flag};
        OFS_CAPTURE: s_d.rdata = s_q.capture;
        OFS_DEV_LIMIT: s_d.rdata = {{(32-DEV_W){1'b0}}, s_q.limit};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with reset defaults
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q.acc <= '0;
      s_q.factor <= RST_STEP_FACTOR;
      s_q.capture <= RST_CAPTURE;
      s_q.limit <= RST_DEV_LIMIT;
      s_q.idx_flag <= 1'b0;
      s_q.dev_flag <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.rvalid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all from flip-flops; only the integer part is visible
  assign enc_position = s_q.acc[ACC_W-1:FRAC_W];
  assign n_event = s_q.idx_flag;
  assign deviation_warn = s_q.dev_flag;
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_factor_reset: assert property (
    $rose(nrst) |-> (s_q.factor == RST_STEP_FACTOR))
    else $error("step factor not one after reset");

  // Index cycles are left out, a clear there overrides the count
  a_bin_count: assert property (
    evt.step && !decimal && !evt.index |=>
    s_q.acc == bin_step($past(s_q.acc), $past(s_q.factor), !$past(evt.dir)))
    else $error("binary count did not move by the factor");

  a_unit_step_up: assert property (
    evt.step && evt.dir && !decimal && !evt.index &&
    (s_q.factor == RST_STEP_FACTOR) |=>
    enc_position == $past(enc_position) + 32'h0000_0001)
    else $error("unit factor did not advance position by one");

  a_dec_frac_range: assert property (
    decimal && evt.step && (s_q.acc[FRAC_W-1:0] <= DEC_MAX) && !evt.index
    |=> s_q.acc[FRAC_W-1:0] <= DEC_MAX)
    else $error("decimal fraction left its range");

  a_idx_flag_set: assert property (
    evt.index |=> n_event ##1 (n_event || $past(flags_clr_idx)))
    else $error("index flag not set or not sticky");

  a_idx_flag_clr: assert property (
    flags_clr_idx && !evt.index |=> !n_event)
    else $error("index flag not cleared by write one");

  a_capture_pos: assert property (
    evt.index |=> s_q.capture == $past(enc_position))
    else $error("capture does not hold the position at index");

  a_clr_on_index: assert property (
    evt.index && clr_on_idx |=> (s_q.acc == '0))
    else $error("position not cleared at index");

  a_dev_raise: assert property (
    dev_cond |=> deviation_warn)
    else $error("deviation warning not raised");

  a_dev_hold: assert property (
    deviation_warn && dev_cond && flags_clr_dev |=> deviation_warn)
    else $error("deviation warning cleared while condition present");

  // A zero limit must never raise the warning on its own
  a_dev_off: assert property (
    (s_q.limit == RST_DEV_LIMIT) && !deviation_warn |=> !deviation_warn)
    else $error("deviation warning raised with check off");

  a_dev_zero_ref: assert property (
    !src_incr && (s_q.limit != RST_DEV_LIMIT) &&
    (abs_diff(enc_position, 32'h0000_0000) >
     {{(32-DEV_W){1'b0}}, s_q.limit}) |=> deviation_warn)
    else $error("full-step deviation not measured against zero");

  a_read_answer: assert property (
    reg_rd && (reg_addr == OFS_CAPTURE) |=>
    reg_rvalid && (reg_rdata == $past(s_q.capture)))
    else $error("capture read not answered next cycle");

endmodule : epa_position_acc

// file: epa_enc_model.sv
`timescale 1ns/1ps
module epa_enc_model (
  // Clock
  clk,
  // Encoder lines
  enc_a,
  enc_b,
  enc_n
);
  input wire logic clk;
  output logic enc_a;
  output logic enc_b;
  output logic enc_n;
  logic [1:0] ph = 2'h0;

  // Gray order 00,01,11,10 on A,B is forward; one phase moves per step
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];
  initial enc_n = 1'b0;

  // Steps are spaced so every count settles before the next one
  task automatic move(input logic fwd, input int n);
    repeat (n) begin
      @(negedge clk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      repeat (4) @(negedge clk);
    end
  endtask : move

  // Index line change, then time for the event to land
  task automatic set_n(input logic v);
    @(negedge clk);
    enc_n = v;
    repeat (4) @(negedge clk);
  endtask : set_n
endmodule : epa_enc_model

// file: tb_encoder_position_accumulator.sv
`timescale 1ns/1ps
module tb_encoder_position_accumulator;
  import epa_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic [CFG_W-1:0] cfg;
  logic bemf_step;
  logic bemf_dir;
  logic [31:0] ramp;
  logic enc_a, enc_b, enc_n;
  logic [31:0] enc_position;
  logic n_event, deviation_warn;
  int fail_count = 0;
  int checks_done = 0;

  epa_enc_model enc (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

  epa_position_acc uut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .encoder_config(cfg),
    .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .bemf_step(bemf_step),
    .bemf_dir(bemf_dir), .ramp_actual_position(ramp),
    .enc_position(enc_position), .n_event(n_event),
    .deviation_warn(deviation_warn));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle strobes, driven on the falling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is looked at one edge after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, e);
  endtask : rd

  task automatic bstep(input logic d);
    @(negedge clk);
    bemf_step = 1'b1;
    bemf_dir = d;
    @(negedge clk);
    bemf_step = 1'b0;
    repeat (4) @(negedge clk);
  endtask : bstep

  task automatic t_reset();
    rd(OFS_STEP_FACTOR, 32'h0001_0000);
    rd(OFS_FLAGS, 32'h0);
    rd(OFS_CAPTURE, 32'h0);
    rd(OFS_DEV_LIMIT, 32'h0);
    rd(7'h34, 32'h0);
  endtask : t_reset

  task automatic t_regs();
    wr(OFS_STEP_FACTOR, 32'hFFFE_8000);
    rd(OFS_STEP_FACTOR, 32'hFFFE_8000);
    wr(OFS_CAPTURE, 32'h1234_5678);
    rd(OFS_CAPTURE, 32'h0);
    wr(OFS_DEV_LIMIT, 32'hFFF0_0000);
    rd(OFS_DEV_LIMIT, 32'h0);
    wr(7'h34, 32'hA5A5_A5A5);
    rd(7'h34, 32'h0);
  endtask : t_regs

  task automatic t_count();
    wr(OFS_STEP_FACTOR, 32'h0001_0000);
    enc.move(1'b1, 4);
    chk(enc_position, 32'h4);
    enc.move(1'b0, 2);
    chk(enc_position, 32'h2);
    wr(OFS_STEP_FACTOR, 32'hFFFF_0000);
    enc.move(1'b1, 3);
    chk(enc_position, 32'hFFFF_FFFF);
  endtask : t_count

  // Half-count factors: binary 1/65536 against decimal 1/10000 units
  task automatic t_frac();
    wr(OFS_STEP_FACTOR, 32'h0000_8000);
    enc.move(1'b1, 3);
    chk(enc_position, 32'h0);
    enc.move(1'b1, 1);
    chk(enc_position, 32'h1);
    cfg = 16'h0C04;
    wr(OFS_STEP_FACTOR, 32'h0000_1388);
    enc.move(1'b1, 2);
    chk(enc_position, 32'h2);
    cfg = 16'h0804;
    wr(OFS_STEP_FACTOR, 32'h0001_0000);
  endtask : t_frac

  task automatic t_index();
    for (int s = 0; s < 4; s++) begin
      cfg = 16'h080C | 16'(s << 6);
      wr(OFS_FLAGS, 32'h1);
      chk({31'h0, n_event}, 32'h0);
      enc.set_n(1'b1);
      chk({31'h0, n_event}, {31'h0, s != 2});
      enc.set_n(1'b0);
      chk({31'h0, n_event}, 32'h1);
    end
    rd(OFS_CAPTURE, 32'h2);
    rd(OFS_FLAGS, 32'h1);
    // Phases now sit at A=1, B=0
    cfg = 16'h0847;
    wr(OFS_FLAGS, 32'h1);
    enc.set_n(1'b1);
    chk({31'h0, n_event}, 32'h0);
    enc.set_n(1'b0);
    cfg = 16'h0845;
    enc.set_n(1'b1);
    chk({31'h0, n_event}, 32'h1);
    enc.set_n(1'b0);
    cfg = 16'h094C;
    enc.move(1'b1, 1);
    enc.set_n(1'b1);
    chk(enc_position, 32'h0);
    rd(OFS_CAPTURE, 32'h3);
    enc.set_n(1'b0);
    cfg = 16'h0804;
  endtask : t_index

  task automatic t_dev();
    enc.move(1'b1, 3);
    chk({31'h0, deviation_warn}, 32'h0);
    wr(OFS_DEV_LIMIT, 32'hFFF0_0002);
    repeat (2) @(negedge clk);
    chk({31'h0, deviation_warn}, 32'h1);
    rd(OFS_DEV_LIMIT, 32'h2);
    wr(OFS_FLAGS, 32'h2);
    chk({31'h0, deviation_warn}, 32'h1);
    ramp = 32'h1;
    repeat (2) @(negedge clk);
    wr(OFS_FLAGS, 32'h2);
    repeat (2) @(negedge clk);
    chk({31'h0, deviation_warn}, 32'h0);
    // Index stays active high so idle N raises no level events
    cfg = 16'h0004;
    ramp = 32'h4;
    bstep(1'b1);
    chk(enc_position, 32'h4);
    bstep(1'b0);
    chk(enc_position, 32'h3);
    chk({31'h0, deviation_warn}, 32'h1);
    wr(OFS_DEV_LIMIT, 32'h0);
    wr(OFS_FLAGS, 32'h2);
    repeat (2) @(negedge clk);
    chk({31'h0, deviation_warn}, 32'h0);
  endtask : t_dev

  // Main sequence
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0;
    // N active high: the idle low index line must not match
    cfg = 16'h0804;
    bemf_step = 1'b0;
    bemf_dir = 1'b0;
    ramp = 32'h0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_count();
    t_frac();
    t_index();
    t_dev();
    wrap_up();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb_encoder_position_accumulator
